// File: verilog/asc_params.svh
`ifndef ASC_PARAMS_SVH
`define ASC_PARAMS_SVH
// register byte offsets
`define ASC_OFS_CTRL_A 8'h00
`define ASC_OFS_CTRL_B 8'h04
`define ASC_OFS_CTRL_C 8'h08
`define ASC_OFS_STAT 8'h0C
`define ASC_OFS_DATA 8'h10
// serial_control_a fields
`define ASC_A_LOOP 7
`define ASC_A_ON 6
`define ASC_A_INV 5
`define ASC_A_LONG 4
`define ASC_A_WAKE 3
`define ASC_A_IDLE_COUNT_START_SEL 2
`define ASC_A_PAR 1
`define ASC_A_ODD 0
// serial_control_b fields
`define ASC_B_TEI 7
`define ASC_B_TCI 6
`define ASC_B_RFI 5
`define ASC_B_ILI 4
`define ASC_B_TXON 3
`define ASC_B_RXON 2
`define ASC_B_STBY 1
`define ASC_B_BRK 0
// serial_control_c fields
`define ASC_C_R8 7
`define ASC_C_T8 6
`define ASC_C_RDMA 5
`define ASC_C_TDMA 4
// serial_status_a fields
`define ASC_S_TE 7
`define ASC_S_TC 6
`define ASC_S_RF 5
`define ASC_S_IDLE 4
`define ASC_S_PE 0
// reset value of control registers
`define ASC_RST_CTRL 8'h00
// bit timing
`define ASC_CLK_HZ 25000000
`define ASC_BAUD 115200
`define ASC_BIT_CYC (`ASC_CLK_HZ / `ASC_BAUD)
// frame lengths in bit times
`define ASC_FRM_SHORT 4'hA
`define ASC_FRM_LONG 4'hB
`endif

// File: verilog/asc_pkg.sv
package asc_pkg;
  // transmit shifter state
  typedef enum logic {TX_IDLE, TX_BUSY} asc_tx_st_t;
  // receive shifter state
  typedef enum logic {RX_IDLE, RX_BUSY} asc_rx_st_t;
endpackage

// File: verilog/asc_top.sv
`timescale 1ns/1ps
`include "asc_params.svh"
// Overview of operation
// - receive pin is input while module on
// - loopback feeds transmitter output into receiver
// - module off sets empty/done, stops tx requests
// - polarity flip inverts every transmitted level
// - length bit selects nine or eight bits
// - wake bit: address mark or idle line
// - idle count starts after stop or start
// - parity generated into msb, checked on receive
// - frames one start, one stop, 10/11 bits
// - tx empty requests cpu or dma
// - tx done enable gates done interrupt
// - rx full requests cpu or dma
// - idle interrupt, rx dma suppresses cpu requests
// - tx enable starts 10/11 ones preamble
// - tx disable finishes current character first
// - tx off-on while busy queues idle
// - rx disable keeps receiver flags unchanged
// - standby mutes rx interrupt, wake clears it
// - break toggle sends one break, then one
// - early break replaces pending preamble
// - tx empty sets on load, after reset
// - idle flag after 10/11 ones
module asc_top
  import asc_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd,
  input wire logic port_pin1_dir,
  output logic rx_pin_dir,
  output logic txd,
  output logic tx_irq,
  output logic rx_irq,
  output logic tx_dma_req,
  output logic rx_dma_req
);

  // ****************************************
  // bus slave
  // ****************************************

  // exact word match of one offset
  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] o);
    reg_hit = (a == o);
  endfunction

  logic [7:0] ctl_a_q; // serial_control_a
  logic [7:0] ctl_b_q; // serial_control_b
  logic t8_q; // ninth transmit bit
  logic rdma_q; // rx_dma_en
  logic tdma_q; // tx_dma_en
  logic [7:0] hold_q; // transmit holding byte
  logic [8:0] rxd_q; // received character
  logic te_q, tc_q, rf_q, idle_q, pe_q; // status flags
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q;
  logic [7:0] rd_mux;
  logic hit_a, hit_b, hit_c, hit_s, hit_d, mapped;
  logic acc, wr, rd;

  assign hit_a = reg_hit(paddr, `ASC_OFS_CTRL_A);
  assign hit_b = reg_hit(paddr, `ASC_OFS_CTRL_B);
  assign hit_c = reg_hit(paddr, `ASC_OFS_CTRL_C);
  assign hit_s = reg_hit(paddr, `ASC_OFS_STAT);
  assign hit_d = reg_hit(paddr, `ASC_OFS_DATA);
  assign mapped = hit_a | hit_b | hit_c | hit_s | hit_d;
  // completion edge of a transfer
  assign acc = psel & penable & pready_q;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;

  // field views
  logic loop_sel, mod_on, inv, long_c, wake_addr, idle_count_start_sel, par_on, odd;
  logic tei, tci, rfi, ili, tx_on, rx_on, stby, brk;
  assign loop_sel = ctl_a_q[`ASC_A_LOOP];
  assign mod_on = ctl_a_q[`ASC_A_ON];
  assign inv = ctl_a_q[`ASC_A_INV];
  assign long_c = ctl_a_q[`ASC_A_LONG];
  assign wake_addr = ctl_a_q[`ASC_A_WAKE];
  assign idle_count_start_sel = ctl_a_q[`ASC_A_IDLE_COUNT_START_SEL];
  assign par_on = ctl_a_q[`ASC_A_PAR];
  assign odd = ctl_a_q[`ASC_A_ODD];
  assign tei = ctl_b_q[`ASC_B_TEI];
  assign tci = ctl_b_q[`ASC_B_TCI];
  assign rfi = ctl_b_q[`ASC_B_RFI];
  assign ili = ctl_b_q[`ASC_B_ILI];
  assign tx_on = ctl_b_q[`ASC_B_TXON];
  assign rx_on = ctl_b_q[`ASC_B_RXON];
  assign stby = ctl_b_q[`ASC_B_STBY];
  assign brk = ctl_b_q[`ASC_B_BRK];

  // frame length follows character length
  logic [3:0] flen;
  assign flen = long_c ? `ASC_FRM_LONG : `ASC_FRM_SHORT;

  // read data selection
  always_comb begin
    rd_mux = '0;
    if (hit_a) begin
      rd_mux = ctl_a_q;
    end else if (hit_b) begin
      rd_mux = ctl_b_q;
    end else if (hit_c) begin
      rd_mux[`ASC_C_R8] = rxd_q[8];
      rd_mux[`ASC_C_T8] = t8_q;
      rd_mux[`ASC_C_RDMA] = rdma_q;
      rd_mux[`ASC_C_TDMA] = tdma_q;
    end else if (hit_s) begin
      rd_mux[`ASC_S_TE] = te_q;
      rd_mux[`ASC_S_TC] = tc_q;
      rd_mux[`ASC_S_RF] = rf_q;
      rd_mux[`ASC_S_IDLE] = idle_q;
      rd_mux[`ASC_S_PE] = pe_q;
    end else if (hit_d) begin
      rd_mux = rxd_q[7:0];
    end
  end

  // no wait state: answer raised in the access phase
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= psel & ~penable;
      pslverr_q <= psel & ~penable & ~mapped;
      prdata_q <= (psel & ~penable & ~pwrite) ? {24'h000000, rd_mux} : '0;
    end
  end
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;

  // ****************************************
  // control registers
  // ****************************************

  logic wake_hit; // receiver leaves standby
  logic tx_rise; // tx_on written from 0 to 1
  logic brk_rise; // break_send written from 0 to 1
  assign tx_rise = wr & hit_b & pwdata[`ASC_B_TXON] & ~tx_on;
  assign brk_rise = wr & hit_b & pwdata[`ASC_B_BRK] & ~brk;

  // serial_control_a
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_a_q <= `ASC_RST_CTRL;
    end else if (wr & hit_a) begin
      ctl_a_q <= pwdata[7:0];
    end
  end

  // serial_control_b; a software write wins over the wake clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_b_q <= `ASC_RST_CTRL;
    end else if (wr & hit_b) begin
      ctl_b_q <= pwdata[7:0];
    end else if (wake_hit) begin
      ctl_b_q[`ASC_B_STBY] <= 1'b0;
    end
  end

  // serial_control_c writable bits
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      t8_q <= 1'b0;
      rdma_q <= 1'b0;
      tdma_q <= 1'b0;
    end else if (wr & hit_c) begin
      t8_q <= pwdata[`ASC_C_T8];
      rdma_q <= pwdata[`ASC_C_RDMA];
      tdma_q <= pwdata[`ASC_C_TDMA];
    end
  end

  // ****************************************
  // baud tick
  // ****************************************

  logic [7:0] div_q;
  logic tick;
  assign tick = mod_on & (div_q == 8'(`ASC_BIT_CYC - 1));

  // generator runs only with the module on
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= '0;
    end else if (!mod_on || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // ****************************************
  // transmitter
  // ****************************************

  asc_tx_st_t tx_st_q;
  logic [3:0] left_q; // bits still to shift
  logic [10:0] sh_q; // frame, lsb first
  logic pre_q; // preamble pending
  logic bpend_q; // break toggled, not yet sent
  logic tail_q; // one mark owed after a break
  logic ld, go_brk, go_pre, go_dat, go_tail, tx_line;
  logic [8:0] tchar;
  logic [10:0] tframe;

  // next frame chosen at the last bit edge, so breaks run back to back
  assign ld = tick & (tx_st_q == TX_IDLE || left_q == 4'h1);
  assign go_brk = tx_on & (brk | bpend_q);
  assign go_pre = tx_on & pre_q & ~go_brk;
  assign go_tail = tail_q & ~go_brk;
  assign go_dat = tx_on & ~te_q & ~go_brk & ~go_pre & ~go_tail;

  // parity replaces the top data bit
  always_comb begin
    tchar = {t8_q, hold_q};
    if (par_on && long_c) begin
      tchar[8] = (^hold_q) ^ odd;
    end else if (par_on) begin
      tchar[7] = (^hold_q[6:0]) ^ odd;
    end
    // start low, stop high, pad ones above a short frame
    tframe = long_c ? {1'b1, tchar, 1'b0} : {2'b11, tchar[7:0], 1'b0};
  end

  // shifter; a cleared tx_on only stops new frames
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_st_q <= TX_IDLE;
      left_q <= '0;
      sh_q <= '1;
    end else if (!mod_on) begin
      tx_st_q <= TX_IDLE;
      left_q <= '0;
      sh_q <= '1;
    end else if (ld) begin
      tx_st_q <= (go_brk | go_pre | go_dat | go_tail) ? TX_BUSY : TX_IDLE;
      left_q <= go_tail ? 4'h1 : ((go_brk | go_pre | go_dat) ? flen : 4'h0);
      if (go_brk) begin
        sh_q <= '0;
      end else if (go_dat) begin
        sh_q <= tframe;
      end else begin
        sh_q <= '1; // preamble, tail or idle
      end
    end else if (tick && tx_st_q == TX_BUSY) begin
      left_q <= left_q - 4'h1;
      sh_q <= {1'b1, sh_q[10:1]};
    end
  end

  // pending requests; a break start drops the preamble
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_q <= 1'b0;
      bpend_q <= 1'b0;
      tail_q <= 1'b0;
    end else begin
      if (tx_rise) begin
        pre_q <= 1'b1;
      end else if (ld & (go_brk | go_pre)) begin
        pre_q <= 1'b0;
      end
      if (brk_rise) begin
        bpend_q <= 1'b1;
      end else if (ld & go_brk) begin
        bpend_q <= 1'b0;
      end
      if (ld & go_brk) begin
        tail_q <= 1'b1;
      end else if (ld) begin
        tail_q <= 1'b0;
      end
    end
  end

  // holding register and empty flag; load sets, data write clears
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_q <= '0;
      te_q <= 1'b1;
    end else begin
      if (wr & hit_d) begin
        hold_q <= pwdata[7:0];
      end
      if (!mod_on || (ld & go_dat)) begin
        te_q <= 1'b1;
      end else if (wr & hit_d) begin
        te_q <= 1'b0;
      end
    end
  end

  // done flag: empty and nothing queued or shifting
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tc_q <= 1'b1;
    end else begin
      tc_q <= ~mod_on | (te_q & tx_st_q == TX_IDLE & ~pre_q & ~bpend_q & ~tail_q);
    end
  end

  // line level before polarity
  assign tx_line = (tx_st_q == TX_BUSY) ? sh_q[0] : 1'b1;

  // pin drive, polarity applied last
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      txd <= 1'b1;
    end else begin
      txd <= tx_line ^ inv;
    end
  end

  // ****************************************
  // receiver
  // ****************************************

  logic rx_s1_q, rx_s2_q; // pin synchroniser
  logic rx_in;
  asc_rx_st_t rx_st_q;
  logic [7:0] rcyc_q; // cycles to next sample
  logic [3:0] rleft_q; // samples still to take
  logic [10:0] rsh_q; // sampled frame
  logic [3:0] ones_q; // consecutive mark bit times
  logic arm_q; // idle allowed after a character
  logic rdone, smp, idle_hit, take, bad_par;
  logic [8:0] rchar;

  // two flops before any logic looks at the pin
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end else begin
      rx_s1_q <= rxd;
      rx_s2_q <= rx_s1_q;
    end
  end

  // loopback only with both directions enabled
  assign rx_in = loop_sel ? (tx_on & rx_on ? tx_line : 1'b1) : rx_s2_q;

  assign smp = (rx_st_q == RX_BUSY) & (rcyc_q == 8'h00);
  assign rdone = smp & (rleft_q == 4'h1);

  // sample mid-bit, lsb first; start bit falls out at rsh_q bottom
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_st_q <= RX_IDLE;
      rcyc_q <= '0;
      rleft_q <= '0;
      rsh_q <= '1;
    end else if (!rx_on || !mod_on) begin
      rx_st_q <= RX_IDLE; // flags are left alone
    end else if (rx_st_q == RX_IDLE) begin
      if (!rx_in) begin
        rx_st_q <= RX_BUSY;
        rcyc_q <= 8'(`ASC_BIT_CYC / 2);
        rleft_q <= flen;
      end
    end else if (smp) begin
      rsh_q <= {rx_in, rsh_q[10:1]};
      rleft_q <= rleft_q - 4'h1;
      rcyc_q <= 8'(`ASC_BIT_CYC - 1);
      if (rleft_q == 4'h1) begin
        rx_st_q <= RX_IDLE;
      end
    end else begin
      rcyc_q <= rcyc_q - 8'h01;
    end
  end

  // the shift into rsh_q lands one edge after rdone, so decode the
  // incoming stop bit together with the held bits
  logic [10:0] rfr;
  assign rfr = {rx_in, rsh_q[10:1]};
  // short frame keeps bit 7 as a copy in bit 8
  assign rchar = long_c ? rfr[9:1] : {rfr[9], rfr[9:2]};
  assign bad_par = par_on & (((long_c ? ^rfr[9:1] : ^rfr[9:2])) != odd);
  // standby drops characters unless an address mark wakes it
  assign take = rdone & (~stby | (wake_addr & rchar[8]));

  // idle counter: ones counted after start or after stop
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ones_q <= '0;
    end else if (!rx_in || (idle_count_start_sel && rx_st_q == RX_BUSY)) begin
      ones_q <= '0;
    end else if (tick && ones_q != flen) begin
      ones_q <= ones_q + 4'h1;
    end
  end
  assign idle_hit = rx_on & (ones_q == flen);
  // wake by address mark or by idle line
  assign wake_hit = stby & (wake_addr ? (rdone & rchar[8]) : idle_hit);

  // receive data and flags; events win over a data read
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rxd_q <= '0;
      rf_q <= 1'b0;
      pe_q <= 1'b0;
      idle_q <= 1'b0;
      arm_q <= 1'b0;
    end else begin
      if (take) begin
        rxd_q <= rchar;
      end
      if (take) begin
        rf_q <= 1'b1;
      end else if (rd & hit_d) begin
        rf_q <= 1'b0;
      end
      if (take & bad_par) begin
        pe_q <= 1'b1;
      end else if (rd & hit_d) begin
        pe_q <= 1'b0;
      end
      if (idle_hit & arm_q) begin
        idle_q <= 1'b1;
      end else if (rd & hit_d) begin
        idle_q <= 1'b0;
      end
      if (take) begin
        arm_q <= 1'b1;
      end else if (idle_hit) begin
        arm_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // requests and pin direction
  // ****************************************

  // cpu or dma routing of the flags
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_irq <= 1'b0;
      tx_dma_req <= 1'b0;
      rx_irq <= 1'b0;
      rx_dma_req <= 1'b0;
      rx_pin_dir <= 1'b0;
    end else begin
      tx_irq <= mod_on & ((tei & ~tdma_q & te_q) | (tci & tc_q));
      tx_dma_req <= mod_on & tei & tdma_q & te_q;
      rx_irq <= ~rdma_q & ~stby & ((rfi & rf_q) | (ili & idle_q));
      rx_dma_req <= rfi & rdma_q & rf_q;
      rx_pin_dir <= mod_on ? 1'b0 : port_pin1_dir;
    end
  end

  // ****************************************
  // checks
  // ****************************************

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_pin_in;
    mod_on |=> !rx_pin_dir;
  endproperty
  a_pin_in: assert property (p_pin_in) else $error("pin not input");

  property p_loop;
    loop_sel && tx_on && rx_on |-> rx_in == tx_line;
  endproperty
  a_loop: assert property (p_loop) else $error("loopback broken");

  property p_off;
    !mod_on |=> te_q && tc_q && !tx_irq && !tx_dma_req;
  endproperty
  a_off: assert property (p_off) else $error("module off flags");

  property p_inv;
    tx_st_q == TX_IDLE |=> txd == !$past(inv);
  endproperty
  a_inv: assert property (p_inv) else $error("idle level polarity");

  property p_pre;
    tx_rise |=> pre_q;
  endproperty
  a_pre: assert property (p_pre) else $error("preamble not queued");

  property p_brk;
    ld && go_brk |=> sh_q == '0 && left_q == $past(flen);
  endproperty
  a_brk: assert property (p_brk) else $error("break frame wrong");

  property p_empty;
    ld && go_dat |=> te_q && tx_st_q == TX_BUSY ##1 !tc_q;
  endproperty
  a_empty: assert property (p_empty) else $error("empty not set");

  property p_rxdma;
    rx_dma_req |-> !rx_irq;
  endproperty
  a_rxdma: assert property (p_rxdma) else $error("rx cpu and dma");

  property p_stby;
    stby |=> !rx_irq;
  endproperty
  a_stby: assert property (p_stby) else $error("standby irq");

endmodule

// File: sim/asc_rem.sv
`timescale 1ns/1ps
`include "asc_params.svh"
// ****************************************
// remote transceiver on the serial lines
// ****************************************
module asc_rem (
  input wire logic clk,
  input wire logic txd,
  input wire logic long_mode,
  output logic rxd
);
  localparam int BIT = `ASC_BIT_CYC; // clocks per bit time
  int cyc = 0; // free cycle count
  int last_start = 0; // cycle of latest start edge
  logic [9:0] got[$]; // captured frames, bits after start
  initial rxd = 1'b1; // line rests at mark between frames
  // cycle counter for start timestamps
  always @(posedge clk) begin
    cyc <= cyc + 1;
  end
  // frame catcher: mid-bit sampling, lsb first, stop kept on top
  initial begin : catcher
    logic [9:0] f;
    int nb;
    forever begin
      @(negedge txd);
      last_start = cyc;
      f = '0;
      nb = long_mode ? 10 : 9;
      repeat (BIT / 2) @(posedge clk);
      // a glitch shorter than half a bit is no start
      if (txd !== 1'b0) begin
        continue;
      end
      for (int i = 0; i < nb; i++) begin
        repeat (BIT) @(posedge clk);
        f[i] = txd;
      end
      got.push_back(f);
    end
  end
  // one frame on the receive line: start, data lsb first, stop
  task automatic send(input logic [8:0] d, input int nd);
    @(posedge clk);
    rxd <= 1'b0;
    repeat (BIT) @(posedge clk);
    for (int i = 0; i < nd; i++) begin
      rxd <= d[i];
      repeat (BIT) @(posedge clk);
    end
    rxd <= 1'b1;
    repeat (BIT) @(posedge clk);
  endtask
endmodule

// File: sim/tb.sv
`timescale 1ns/1ps
`include "asc_params.svh"
module tb;
  localparam int BIT = `ASC_BIT_CYC; // clocks per bit time
  localparam int LIMIT = 80000; // hang ceiling in cycles
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rxd;
  logic port_pin1_dir = 1'b1; // direction bit asks for output
  logic rx_pin_dir;
  logic txd;
  logic tx_irq;
  logic rx_irq;
  logic tx_dma_req;
  logic rx_dma_req;
  logic long_mode = 1'b0; // tells the remote the frame size
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  int t0;
  logic [31:0] rd;
  logic err;
  logic [9:0] fr;
  // character formats: control a, data, frame after start bit
  logic [7:0] mode_a[5] = '{8'h40, 8'h53, 8'h52, 8'h42, 8'h43};
  logic [7:0] mode_d[5] = '{8'hA5, 8'h5A, 8'h5A, 8'h03, 8'h03};
  logic [9:0] mode_f[5] = '{10'h1A5, 10'h35A, 10'h25A, 10'h103, 10'h183};

  asc_top u_dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd(rxd), .port_pin1_dir(port_pin1_dir), .rx_pin_dir(rx_pin_dir), .txd(txd),
    .tx_irq(tx_irq), .rx_irq(rx_irq), .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req));
  asc_rem u_rem (.clk(clk), .txd(txd), .long_mode(long_mode), .rxd(rxd));

  always #20 clk = ~clk; // 25 MHz
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      error_cnt++;
      summarize();
    end
  end
  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer; request held until pready seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // access phase held until pready is seen high at a rising edge;
    // only the hang guard ends a wait that never answers
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    check(pready, 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, {24'h0, d}, r, e);
  endtask
  // masked read and compare
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check(r & m, exp);
  endtask
  task automatic settle();
    repeat (4) @(posedge clk);
  endtask
  task automatic bits(input int n);
    repeat (n * BIT) @(posedge clk);
  endtask
  task automatic frame(output logic [9:0] f);
    wait (u_rem.got.size() != 0);
    f = u_rem.got.pop_front();
  endtask
  task automatic summarize();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    rc(`ASC_OFS_STAT, 32'hFF, 32'hC0);
    check(rx_pin_dir, 1'b1);
    apb(1'b0, 8'h20, 32'h0, rd, err); // unmapped place refuses
    check(err, 1'b1);
    check(rd, 32'h0);
    wr(`ASC_OFS_CTRL_A, 8'h3F);
    rc(`ASC_OFS_CTRL_A, 32'hFFFFFFFF, 32'h3F);
    wr(`ASC_OFS_CTRL_A, 8'h60);
    settle();
    check(txd, 1'b0);
    wr(`ASC_OFS_CTRL_A, 8'h40);
    settle();
    check(txd, 1'b1);
    check(rx_pin_dir, 1'b0);
    // enables only written once the module is on
    wr(`ASC_OFS_CTRL_B, 8'h08);
    t0 = u_rem.cyc;
    // five character formats in turn
    for (int i = 0; i < 5; i++) begin
      long_mode = mode_a[i][4];
      wr(`ASC_OFS_CTRL_A, mode_a[i]);
      wr(`ASC_OFS_DATA, mode_d[i]);
      frame(fr);
      check(fr, mode_f[i]);
      if (i == 0) begin
        check(u_rem.last_start - t0 >= 10 * BIT, 1'b1);
      end
      bits(2);
    end
    long_mode = 1'b0;
    wr(`ASC_OFS_CTRL_A, 8'h40);
    // transmitter request routing
    wr(`ASC_OFS_CTRL_B, 8'h88);
    settle();
    check(tx_irq, 1'b1);
    check(tx_dma_req, 1'b0);
    wr(`ASC_OFS_CTRL_C, 8'h10);
    settle();
    check(tx_dma_req, 1'b1);
    check(tx_irq, 1'b0);
    wr(`ASC_OFS_CTRL_C, 8'h00);
    wr(`ASC_OFS_CTRL_B, 8'h48);
    settle();
    check(tx_irq, 1'b1);
    wr(`ASC_OFS_CTRL_B, 8'h08);
    settle();
    check(tx_irq, 1'b0);
    // transmitter switched off in mid-frame still ends the frame
    wr(`ASC_OFS_DATA, 8'h5A);
    bits(3);
    wr(`ASC_OFS_CTRL_B, 8'h00);
    frame(fr);
    check(fr, 10'h15A);
    // single break, then mark
    wr(`ASC_OFS_CTRL_B, 8'h09);
    wr(`ASC_OFS_CTRL_B, 8'h08);
    frame(fr);
    check(fr, 10'h000);
    bits(2);
    check(txd, 1'b1);
    // module off forces empty and done, mutes transmitter
    wr(`ASC_OFS_CTRL_B, 8'hC8);
    wr(`ASC_OFS_CTRL_A, 8'h00);
    settle();
    check(tx_irq, 1'b0);
    rc(`ASC_OFS_STAT, 32'hC0, 32'hC0);
    check(rx_pin_dir, 1'b1);
    // receiver, idle detection and request routing
    wr(`ASC_OFS_CTRL_A, 8'h40);
    wr(`ASC_OFS_CTRL_B, 8'h14);
    u_rem.send(9'h03C, 8);
    rc(`ASC_OFS_STAT, 32'h20, 32'h20);
    check(rx_irq, 1'b0);
    bits(12);
    rc(`ASC_OFS_STAT, 32'h10, 32'h10);
    check(rx_irq, 1'b1);
    wr(`ASC_OFS_CTRL_C, 8'h20);
    settle();
    check(rx_irq, 1'b0);
    check(rx_dma_req, 1'b0);
    wr(`ASC_OFS_CTRL_B, 8'h24);
    settle();
    check(rx_dma_req, 1'b1);
    wr(`ASC_OFS_CTRL_C, 8'h00);
    settle();
    check(rx_irq, 1'b1);
    wr(`ASC_OFS_CTRL_B, 8'h20);
    rc(`ASC_OFS_STAT, 32'h30, 32'h30);
    rc(`ASC_OFS_DATA, 32'hFF, 32'h3C);
    // standby with address-mark wake
    wr(`ASC_OFS_CTRL_A, 8'h48);
    wr(`ASC_OFS_CTRL_B, 8'h26);
    u_rem.send(9'h055, 8);
    check(rx_irq, 1'b0);
    rc(`ASC_OFS_CTRL_B, 32'hFF, 32'h26);
    u_rem.send(9'h0AA, 8);
    rc(`ASC_OFS_CTRL_B, 32'h02, 32'h00);
    check(rx_irq, 1'b1);
    rc(`ASC_OFS_DATA, 32'hFF, 32'hAA);
    // long character with odd parity, then a short even parity error
    wr(`ASC_OFS_CTRL_A, 8'h53);
    u_rem.send(9'h1A5, 9);
    rc(`ASC_OFS_STAT, 32'h21, 32'h20);
    rc(`ASC_OFS_CTRL_C, 32'h80, 32'h80);
    rc(`ASC_OFS_DATA, 32'hFF, 32'hA5);
    wr(`ASC_OFS_CTRL_A, 8'h42);
    u_rem.send(9'h001, 8);
    rc(`ASC_OFS_STAT, 32'h21, 32'h21);
    rc(`ASC_OFS_DATA, 32'hFF, 32'h01);
    // idle-line wake: a quiet line ends standby by itself
    wr(`ASC_OFS_CTRL_A, 8'h40);
    wr(`ASC_OFS_CTRL_B, 8'h26);
    bits(11);
    rc(`ASC_OFS_CTRL_B, 32'h02, 32'h00);
    // loopback: transmitted byte comes back on the receiver
    wr(`ASC_OFS_CTRL_A, 8'hC0);
    wr(`ASC_OFS_CTRL_B, 8'h0C);
    wr(`ASC_OFS_DATA, 8'h96);
    bits(26);
    rc(`ASC_OFS_DATA, 32'hFF, 32'h96);
    summarize();
  end
endmodule
